/* pkt_filter_pkg.sv */
// Package: register indices, pages, field positions, reset values and engine states
// Assumes: the register index is haddr[11:2]; the byte address is four times the index
package pkt_filter_pkg;

	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [9:0] IDX_LEN_LIMIT = 10'h127;
	localparam logic [9:0] IDX_FIX_PTR = 10'h128;
	localparam logic [9:0] IDX_ADDR_POS = 10'h129;
	localparam logic [9:0] IDX_FIRST_LEN = 10'h12A;
	localparam logic [9:0] IDX_MATCH0 = 10'h12B;
	localparam logic [9:0] IDX_MASK0 = 10'h12C;
	localparam logic [9:0] IDX_MATCH1 = 10'h12D;
	localparam logic [9:0] IDX_MASK1 = 10'h12E;
	localparam logic [9:0] IDX_CTRL = 10'h200;
	localparam logic [9:0] IDX_STATUS = 10'h201;

	// ----------------------------------------
	// Pages (index bits 9:8)
	// ----------------------------------------
	localparam logic [1:0] PAGE_PKT = 2'h0;
	localparam logic [1:0] PAGE_CFG_MEM = 2'h1;
	localparam logic [1:0] PAGE_OWN = 2'h2;
	localparam logic [1:0] PAGE_CFG_REG = 2'h3;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int CTRL_FIXED_BIT = 0;
	localparam int CTRL_LOAD_BIT = 1;
	localparam logic [7:0] LEN_LIMIT_RST = 8'h00;
	localparam logic [7:0] FIX_PTR_RST = 8'h00;
	localparam logic [7:0] ADDR_POS_RST = 8'h00;
	localparam logic [7:0] FIRST_LEN_RST = 8'h00;
	localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_RX = 4'b0001,
		ST_RX_FLUSH = 4'b0010,
		ST_F_START = 4'b0011,
		ST_F_MATCH = 4'b0100,
		ST_F_MASK = 4'b0101,
		ST_F_CMP = 4'b0110,
		ST_F_END = 4'b0111,
		ST_F_CNT = 4'b1000,
		ST_L_ADDR = 4'b1001,
		ST_L_AWAIT = 4'b1010,
		ST_L_DATA = 4'b1011
	} state_t;

endpackage : pkt_filter_pkg

/* byte_ram.sv */
// Two-port byte memory with registered read data on both ports
// Assumes: both ports never write the same word in the same cycle
`timescale 1ns/1ps
`default_nettype none
module byte_ram #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock
	input wire logic clk,
	// Port A
	input wire logic a_en,
	input wire logic a_we,
	input wire logic [AW-1:0] a_addr,
	input wire logic [DW-1:0] a_wdata,
	output logic [DW-1:0] a_rdata,
	// Port B
	input wire logic b_en,
	input wire logic b_we,
	input wire logic [AW-1:0] b_addr,
	input wire logic [DW-1:0] b_wdata,
	output logic [DW-1:0] b_rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (a_en)
		begin
			if (a_we)
				mem[a_addr] <= a_wdata;
			a_rdata <= mem[a_addr];
		end
	end

	always_ff @(posedge clk)
	begin
		if (b_en)
		begin
			if (b_we)
				mem[b_addr] <= b_wdata;
			b_rdata <= mem[b_addr];
		end
	end
endmodule : byte_ram
`default_nettype wire

/* masked_match.sv */
// One address byte compare under a mask
// Assumes: inputs come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none
module masked_match (
	// Compare operands
	input wire logic [7:0] rx_byte,
	input wire logic [7:0] match_byte,
	input wire logic [7:0] mask_byte,
	// Result
	output logic hit
);
	assign hit = ((rx_byte & mask_byte) == (match_byte & mask_byte));
endmodule : masked_match
`default_nettype wire

/* pkt_filter.sv */
// Packet length check, receive address filter and static config fix loader
// Assumes: AHB-Lite single slave, rx bytes from logic on hclk, payload without sync and checksum
// Function
// - variable mode: limit is maximum length
// - fixed mode: limit is exact length
// - length counts bytes between sync and checksum
// - zero pointer: no config copying
// - nonzero pointer: copy pairs into config registers
// - pointer is low byte in 0x100 page
// - list holds address byte then data byte
// - zero address byte ends the list
// - position register locates first address byte
// - compare first-field-length bytes from that position
// - match and mask bytes alternate from 0x12B
// - byte after field: zero or next count
// - variable mode: first byte is length
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module pkt_filter
	import pkt_filter_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Received payload stream
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	output logic rx_ready,
	// Results
	output logic pkt_accept,
	output logic pkt_drop,
	output logic [7:0] pkt_length,
	output logic [7:0] tx_length,
	output logic fix_busy
);
	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	function automatic logic mapped(input logic [9:0] idx);
		mapped = (idx[9:8] != PAGE_OWN) || (idx == IDX_CTRL) || (idx == IDX_STATUS);
	endfunction : mapped

	logic acc;
	logic dp_rd_q, dp_wr_q, rd_wait_q;
	logic [9:0] dp_idx_q;
	logic [1:0] dp_page;
	logic wr_own;

	assign acc = hsel && (htrans & HTRANS_NONSEQ_BIT) != 2'h0 && hready && hsize == HSIZE_WORD;
	assign dp_page = dp_idx_q[9:8];
	// Reads wait one cycle so port A is only ever used in the data phase
	assign hreadyout = !(dp_rd_q && !rd_wait_q);
	assign hresp = 1'b0;
	assign wr_own = dp_wr_q && dp_page == PAGE_OWN;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_rd_q <= 1'b0;
			dp_wr_q <= 1'b0;
			dp_idx_q <= 10'h000;
			rd_wait_q <= 1'b0;
		end
		else
		begin
			rd_wait_q <= dp_rd_q && !rd_wait_q;
			if (hready)
			begin
				dp_rd_q <= acc && !hwrite;
				dp_wr_q <= acc && hwrite && mapped(haddr[11:2]) && haddr[31:12] == 20'h00000;
				dp_idx_q <= (haddr[31:12] == 20'h00000) ? haddr[11:2] : IDX_STATUS + 10'h001;
			end
		end
	end

	// ----------------------------------------
	// Shadowed registers and control
	// ----------------------------------------
	logic [7:0] len_limit_q, fix_ptr_q, addr_pos_q, first_len_q;
	logic fixed_q, load_req_q, load_done_q, last_accept_q, last_drop_q;
	logic load_take;
	logic [7:0] tx_first_q;
	state_t st_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			len_limit_q <= LEN_LIMIT_RST;
			fix_ptr_q <= FIX_PTR_RST;
			addr_pos_q <= ADDR_POS_RST;
			first_len_q <= FIRST_LEN_RST;
			tx_first_q <= 8'h00;
		end
		else if (dp_wr_q)
		begin
			case (dp_idx_q)
				IDX_LEN_LIMIT: len_limit_q <= hwdata[7:0];
				IDX_FIX_PTR: fix_ptr_q <= hwdata[7:0];
				IDX_ADDR_POS: addr_pos_q <= hwdata[7:0];
				IDX_FIRST_LEN: first_len_q <= hwdata[7:0];
				10'h000: tx_first_q <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fixed_q <= 1'b0;
			load_req_q <= 1'b0;
		end
		else
		begin
			if (wr_own && dp_idx_q == IDX_CTRL)
				fixed_q <= hwdata[CTRL_FIXED_BIT];
			// New request wins over the one being taken
			if (wr_own && dp_idx_q == IDX_CTRL && hwdata[CTRL_LOAD_BIT])
				load_req_q <= 1'b1;
			else if (load_take)
				load_req_q <= 1'b0;
		end
	end

	// Length used for transmit follows the mode
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tx_length <= 8'h00;
		else
			tx_length <= fixed_q ? len_limit_q : tx_first_q;
	end

	// ----------------------------------------
	// Memories
	// ----------------------------------------
	logic [7:0] pkt_a_rd, bb_a_rd, creg_a_rd, pkt_b_rd, bb_b_rd;
	logic a_act;
	logic pkt_b_en, pkt_b_we, bb_b_en, creg_b_en;
	logic [7:0] pkt_b_addr, pkt_b_wd, bb_b_addr, creg_b_addr, creg_b_wd;

	assign a_act = (dp_rd_q && !rd_wait_q) || dp_wr_q;

	byte_ram #(.AW(8), .DW(8)) u_pkt_ram (
		.clk(hclk),
		.a_en(a_act && dp_page == PAGE_PKT), .a_we(dp_wr_q), .a_addr(dp_idx_q[7:0]),
		.a_wdata(hwdata[7:0]), .a_rdata(pkt_a_rd),
		.b_en(pkt_b_en), .b_we(pkt_b_we), .b_addr(pkt_b_addr),
		.b_wdata(pkt_b_wd), .b_rdata(pkt_b_rd)
	);

	byte_ram #(.AW(8), .DW(8)) u_bb_ram (
		.clk(hclk),
		.a_en(a_act && dp_page == PAGE_CFG_MEM), .a_we(dp_wr_q), .a_addr(dp_idx_q[7:0]),
		.a_wdata(hwdata[7:0]), .a_rdata(bb_a_rd),
		.b_en(bb_b_en), .b_we(1'b0), .b_addr(bb_b_addr),
		.b_wdata(8'h00), .b_rdata(bb_b_rd)
	);

	byte_ram #(.AW(8), .DW(8)) u_creg_ram (
		.clk(hclk),
		.a_en(a_act && dp_page == PAGE_CFG_REG), .a_we(dp_wr_q), .a_addr(dp_idx_q[7:0]),
		.a_wdata(hwdata[7:0]), .a_rdata(creg_a_rd),
		.b_en(creg_b_en), .b_we(1'b1), .b_addr(creg_b_addr),
		.b_wdata(creg_b_wd), .b_rdata()
	);

	always_comb
	begin
		hrdata = 32'h00000000;
		if (rd_wait_q)
		begin
			case (dp_page)
				PAGE_PKT: hrdata = {24'h000000, pkt_a_rd};
				PAGE_CFG_REG: hrdata = {24'h000000, creg_a_rd};
				PAGE_CFG_MEM:
				begin
					case (dp_idx_q)
						IDX_LEN_LIMIT: hrdata = {24'h000000, len_limit_q};
						IDX_FIX_PTR: hrdata = {24'h000000, fix_ptr_q};
						IDX_ADDR_POS: hrdata = {24'h000000, addr_pos_q};
						IDX_FIRST_LEN: hrdata = {24'h000000, first_len_q};
						default: hrdata = {24'h000000, bb_a_rd};
					endcase
				end
				default:
				begin
					if (dp_idx_q == IDX_CTRL)
						hrdata = {31'h00000000, fixed_q};
					else if (dp_idx_q == IDX_STATUS)
						hrdata = {16'h0000, pkt_length, 4'h0, load_done_q, last_drop_q,
							last_accept_q, st_q != ST_IDLE};
				end
			endcase
		end
	end

	// ----------------------------------------
	// Engine: receive, filter, fix loader
	// ----------------------------------------
	logic [7:0] cnt_q, exp_q, bptr_q, n_q, i_q, match_q, maddr_q;
	logic bad_q, field_ok_q, hit, rx_take;
	logic [7:0] exp_now, cnt_inc;
	logic bad_now;

	assign rx_ready = (st_q == ST_IDLE && !load_req_q) || st_q == ST_RX || st_q == ST_RX_FLUSH;
	assign rx_take = rx_valid && rx_ready;
	assign load_take = st_q == ST_IDLE && load_req_q;
	assign fix_busy = st_q == ST_L_ADDR || st_q == ST_L_AWAIT || st_q == ST_L_DATA;
	assign cnt_inc = 8'(cnt_q + 8'h01);
	// First byte carries the length in variable mode
	assign exp_now = (st_q == ST_IDLE) ? (fixed_q ? len_limit_q : rx_data) : exp_q;
	// Judged afresh on each first byte so an earlier oversize frame does not stick
	assign bad_now = (st_q == ST_IDLE) ? (!fixed_q && rx_data > len_limit_q) : bad_q;

	masked_match u_match (
		.rx_byte(pkt_b_rd),
		.match_byte(match_q),
		.mask_byte(bb_b_rd),
		.hit(hit)
	);

	always_comb
	begin
		pkt_b_en = 1'b0;
		pkt_b_we = 1'b0;
		pkt_b_addr = cnt_q;
		pkt_b_wd = rx_data;
		bb_b_en = 1'b0;
		bb_b_addr = bptr_q;
		creg_b_en = 1'b0;
		creg_b_addr = maddr_q;
		creg_b_wd = bb_b_rd;
		case (st_q)
			ST_IDLE, ST_RX:
			begin
				pkt_b_en = rx_take;
				pkt_b_we = rx_take;
				pkt_b_addr = (st_q == ST_IDLE) ? 8'h00 : cnt_q;
			end
			ST_F_MATCH, ST_F_END, ST_L_ADDR: bb_b_en = 1'b1;
			ST_F_MASK:
			begin
				bb_b_en = 1'b1;
				bb_b_addr = 8'(bptr_q + 8'h01);
				pkt_b_en = 1'b1;
				pkt_b_addr = 8'(addr_pos_q + i_q);
			end
			ST_L_AWAIT:
			begin
				bb_b_en = 1'b1;
				bb_b_addr = 8'(bptr_q + 8'h01);
			end
			ST_L_DATA: creg_b_en = 1'b1;
			default: ;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q <= ST_IDLE;
			cnt_q <= 8'h00;
			exp_q <= 8'h00;
			bad_q <= 1'b0;
			bptr_q <= 8'h00;
			n_q <= 8'h00;
			i_q <= 8'h00;
			match_q <= 8'h00;
			maddr_q <= 8'h00;
			field_ok_q <= 1'b0;
			pkt_accept <= 1'b0;
			pkt_drop <= 1'b0;
			pkt_length <= 8'h00;
			load_done_q <= 1'b0;
			last_accept_q <= 1'b0;
			last_drop_q <= 1'b0;
		end
		else
		begin
			pkt_accept <= 1'b0;
			pkt_drop <= 1'b0;
			case (st_q)
				ST_IDLE, ST_RX:
				begin
					if (load_take)
					begin
						load_done_q <= 1'b0;
						bptr_q <= fix_ptr_q;
						st_q <= (fix_ptr_q == 8'h00) ? ST_IDLE : ST_L_ADDR;
						load_done_q <= (fix_ptr_q == 8'h00);
					end
					else if (rx_take)
					begin
						// Only payload bytes arrive here, so each one counts
						cnt_q <= cnt_inc;
						exp_q <= exp_now;
						bad_q <= bad_now;
						if (cnt_inc == exp_now)
						begin
							pkt_length <= cnt_inc;
							st_q <= bad_now ? ST_IDLE : ST_F_START;
							pkt_drop <= bad_now;
							last_drop_q <= bad_now;
							last_accept_q <= 1'b0;
						end
						else if (rx_last)
						begin
							// Short frame: too few bytes for the length
							pkt_length <= cnt_inc;
							pkt_drop <= 1'b1;
							last_drop_q <= 1'b1;
							last_accept_q <= 1'b0;
							st_q <= ST_IDLE;
						end
						else
							st_q <= ST_RX;
					end
					if (st_q == ST_IDLE && !load_take && !rx_take)
						cnt_q <= 8'h00;
					if (st_q == ST_IDLE && rx_take && !load_take)
						cnt_q <= 8'h01;
				end
				ST_F_START:
				begin
					cnt_q <= 8'h00;
					bptr_q <= IDX_MATCH0[7:0];
					n_q <= first_len_q;
					i_q <= 8'h00;
					field_ok_q <= 1'b1;
					if (first_len_q == 8'h00)
					begin
						// Zero length turns filtering off
						pkt_accept <= 1'b1;
						last_accept_q <= 1'b1;
						st_q <= ST_IDLE;
					end
					else
						st_q <= ST_F_MATCH;
				end
				ST_F_MATCH: st_q <= ST_F_MASK;
				ST_F_MASK:
				begin
					match_q <= bb_b_rd;
					st_q <= ST_F_CMP;
				end
				ST_F_CMP:
				begin
					field_ok_q <= field_ok_q && hit;
					bptr_q <= 8'(bptr_q + 8'h02);
					i_q <= cnt_inc == 8'h00 ? 8'h00 : 8'(i_q + 8'h01);
					st_q <= (8'(i_q + 8'h01) == n_q) ? ST_F_END : ST_F_MATCH;
				end
				ST_F_END:
				begin
					if (field_ok_q)
					begin
						pkt_accept <= 1'b1;
						last_accept_q <= 1'b1;
						st_q <= ST_IDLE;
					end
					else
						st_q <= ST_F_CNT;
				end
				ST_F_CNT:
				begin
					// Count byte after the pairs chains another field
					if (bb_b_rd == 8'h00)
					begin
						pkt_drop <= 1'b1;
						last_drop_q <= 1'b1;
						st_q <= ST_IDLE;
					end
					else
					begin
						n_q <= bb_b_rd;
						// Step past the count byte to the next match byte
						bptr_q <= 8'(bptr_q + 8'h01);
						i_q <= 8'h00;
						field_ok_q <= 1'b1;
						st_q <= ST_F_MATCH;
					end
				end
				ST_L_ADDR: st_q <= ST_L_AWAIT;
				ST_L_AWAIT:
				begin
					maddr_q <= bb_b_rd;
					if (bb_b_rd == 8'h00)
					begin
						load_done_q <= 1'b1;
						st_q <= ST_IDLE;
					end
					else
						st_q <= ST_L_DATA;
				end
				ST_L_DATA:
				begin
					bptr_q <= 8'(bptr_q + 8'h02);
					st_q <= ST_L_ADDR;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule : pkt_filter
`default_nettype wire

/* pkt_filter_properties.sv */
// Checker: bus timing, result pulses and length relations seen at the filter ports
// Assumes: bound into pkt_filter; shadows of limit and mode are tracked from bus writes
`timescale 1ns/1ps
`default_nettype none
module pkt_filter_properties
	import pkt_filter_pkg::*;
(
	// Bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	// Stream and results
	input wire logic rx_ready,
	input wire logic pkt_accept,
	input wire logic pkt_drop,
	input wire logic [7:0] pkt_length,
	input wire logic [7:0] tx_length,
	input wire logic fix_busy
);
	logic taken;
	logic wr_q;
	logic [9:0] idx_q;
	logic [7:0] limit_q;
	logic fixed_q;
	logic [1:0] quiet_q;
	assign taken = hsel && htrans[1] && hready && (hsize == HSIZE_WORD) && (haddr[31:12] == 20'h0);
	// ----------------------------------------
	// Shadow of limit and mode
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q <= 1'b0;
			idx_q <= 10'h000;
			limit_q <= LEN_LIMIT_RST;
			fixed_q <= 1'b0;
			quiet_q <= 2'h0;
		end
		else
		begin
			if (hready)
			begin
				wr_q <= taken && hwrite;
				idx_q <= haddr[11:2];
			end
			if (wr_q && hready && idx_q == IDX_LEN_LIMIT)
				limit_q <= hwdata[7:0];
			if (wr_q && hready && idx_q == IDX_CTRL)
				fixed_q <= hwdata[CTRL_FIXED_BIT];
			// Results lag a settings write by a cycle or two
			if (wr_q && hready)
				quiet_q <= 2'h0;
			else if (quiet_q != 2'h3)
				quiet_q <= quiet_q + 2'h1;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_EXCL: assert property (!(pkt_accept && pkt_drop))
		else $error("accept and drop together");
	AST_ACC_PULSE: assert property (pkt_accept |=> !pkt_accept)
		else $error("accept longer than one cycle");
	AST_RD_WAIT: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	AST_WR_NOWAIT: assert property (taken && hwrite |=> hreadyout)
		else $error("write stalled");
	AST_TX_FIXED: assert property (fixed_q && quiet_q == 2'h3 |-> tx_length == limit_q)
		else $error("fixed length not the limit");
	AST_FIX_EXACT: assert property (pkt_accept && fixed_q && quiet_q == 2'h3 |-> pkt_length == limit_q)
		else $error("fixed packet length differs");
	AST_VAR_MAX: assert property (pkt_accept && !fixed_q && quiet_q == 2'h3 |-> pkt_length <= limit_q)
		else $error("variable packet over limit accepted");
	AST_LOAD_BLOCK: assert property (fix_busy |-> !rx_ready)
		else $error("stream open during load");
	COV_ACC: cover property (pkt_accept && fixed_q);
	COV_DROP: cover property (pkt_drop);
	COV_LOAD: cover property ($fell(fix_busy));
endmodule : pkt_filter_properties
bind pkt_filter pkt_filter_properties i_pkt_filter_properties (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .rx_ready(rx_ready), .pkt_accept(pkt_accept), .pkt_drop(pkt_drop),
	.pkt_length(pkt_length), .tx_length(tx_length), .fix_busy(fix_busy));
`default_nettype wire

/* ahb_host_model.sv */
// Host model: single-word AHB-Lite master with register write and read tasks
// Assumes: one slave whose hreadyout is the bus hready; tasks start right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model
	import pkt_filter_pkg::*;
(
	// Clock and answer
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
	end
	// ----------------------------------------
	// Transfers
	// ----------------------------------------
	task automatic xfer(input logic [9:0] idx, input logic w, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {20'h0, idx, 2'h0};
		htrans <= HTRANS_NONSEQ_BIT;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		r = hrdata;
		// Stale data is not left on the bus
		hwdata <= ~d;
	endtask : xfer
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] r;
		xfer(idx, 1'b1, {24'h0, d}, r);
	endtask : wr
	task automatic rd(input logic [9:0] idx, output logic [31:0] r);
		xfer(idx, 1'b0, 32'h0, r);
	endtask : rd
endmodule : ahb_host_model
`default_nettype wire

/* tb.sv */
// Testbench: registers, fixed and variable length, address filter and fix loader
// Assumes: host model drives the bus; the bench feeds the payload stream itself
`timescale 1ns/1ps
`default_nettype none
module tb
	import pkt_filter_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, rx_ready, pkt_accept, pkt_drop, fix_busy;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] pkt_length, tx_length;
	logic rx_valid = 1'b0;
	logic rx_last = 1'b0;
	logic [7:0] rx_data = 8'h00;
	int err_total = 0;
	int samples_checked = 0;
	always #10 hclk = ~hclk;
	pkt_filter i_pkt_filter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
		.rx_ready(rx_ready), .pkt_accept(pkt_accept), .pkt_drop(pkt_drop), .pkt_length(pkt_length),
		.tx_length(tx_length), .fix_busy(fix_busy));
	ahb_host_model i_ahb_host_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		i_ahb_host_model.wr(idx, d);
	endtask : wr
	task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		i_ahb_host_model.rd(idx, r);
		chk(r, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask : rdchk
	// Sends one frame, rx_last on its final byte, then judges the result pulse
	task automatic send(input logic [7:0] b[$], input logic acc, input logic [7:0] len);
		int n;
		foreach (b[i])
		begin
			rx_valid <= 1'b1;
			rx_data <= b[i];
			rx_last <= (i == b.size() - 1);
			@(posedge hclk);
			n = 0;
			while (!rx_ready && n < 100)
			begin
				@(posedge hclk);
				n++;
			end
		end
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		rx_data <= ~rx_data;
		n = 0;
		while (pkt_accept !== 1'b1 && pkt_drop !== 1'b1 && n < 100)
		begin
			@(posedge hclk);
			n++;
		end
		chk({31'h0, pkt_accept}, {31'h0, acc});
		chk({31'h0, pkt_drop}, {31'h0, !acc});
		if (acc)
			chk({24'h0, pkt_length}, {24'h0, len});
	endtask : send
	task automatic load;
		int n;
		wr(IDX_CTRL, 8'h02);
		repeat (2) @(posedge hclk);
		n = 0;
		while (fix_busy !== 1'b0 && n < 200)
		begin
			@(posedge hclk);
			n++;
		end
		chk({31'h0, fix_busy}, 32'h0);
	endtask : load
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		logic [9:0] idx;
		for (int i = 0; i < 4; i++)
		begin
			idx = IDX_LEN_LIMIT + 10'(i);
			rdchk(idx, 32'h0);
			wr(idx, 8'h5A + 8'(i));
			rdchk(idx, 32'h5A + 32'(i));
		end
		rdchk(10'h2F0, 32'h0);
		$display("done regs");
	endtask : t_regs
	task automatic t_fixed;
		wr(IDX_CTRL, 8'h01);
		wr(IDX_LEN_LIMIT, 8'h03);
		wr(IDX_FIRST_LEN, 8'h00);
		send('{8'h11, 8'h22, 8'h33}, 1'b1, 8'h03);
		chk({24'h0, tx_length}, 32'h3);
		send('{8'h44, 8'h55}, 1'b0, 8'h00);
		$display("done fixed");
	endtask : t_fixed
	task automatic t_var;
		wr(IDX_CTRL, 8'h00);
		wr(IDX_LEN_LIMIT, 8'h04);
		send('{8'h03, 8'hAA, 8'hBB}, 1'b1, 8'h03);
		send('{8'h04, 8'h01, 8'h02, 8'h03}, 1'b1, 8'h04);
		send('{8'h05, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b0, 8'h00);
		wr(10'h000, 8'h05);
		// Length register follows the index-0 byte two edges later
		repeat (2) @(posedge hclk);
		chk({24'h0, tx_length}, 32'h5);
		$display("done variable");
	endtask : t_var
	task automatic t_filter;
		wr(IDX_CTRL, 8'h01);
		wr(IDX_LEN_LIMIT, 8'h03);
		wr(IDX_ADDR_POS, 8'h01);
		wr(IDX_FIRST_LEN, 8'h01);
		wr(IDX_MATCH0, 8'hA5);
		wr(IDX_MASK0, 8'hF0);
		wr(IDX_MATCH1, 8'h00);
		send('{8'h00, 8'hAF, 8'h00}, 1'b1, 8'h03);
		send('{8'h00, 8'hB5, 8'h00}, 1'b0, 8'h00);
		wr(IDX_MATCH1, 8'h01);
		wr(IDX_MASK1, 8'hB5);
		wr(10'h12F, 8'hFF);
		wr(10'h130, 8'h00);
		send('{8'h00, 8'hB5, 8'h00}, 1'b1, 8'h03);
		wr(IDX_FIRST_LEN, 8'h00);
		$display("done filter");
	endtask : t_filter
	task automatic t_fix;
		logic [7:0] lst[7] = '{8'h05, 8'h46, 8'h07, 8'h78, 8'h00, 8'h08, 8'h55};
		logic [31:0] r;
		wr(10'h305, 8'h99);
		wr(10'h307, 8'h11);
		wr(10'h308, 8'h22);
		wr(IDX_FIX_PTR, 8'h00);
		load();
		rdchk(10'h305, 32'h99);
		i_ahb_host_model.rd(IDX_STATUS, r);
		chk({31'h0, r[3]}, 32'h1);
		foreach (lst[i]) wr(10'h140 + 10'(i), lst[i]);
		wr(IDX_FIX_PTR, 8'h40);
		load();
		rdchk(10'h305, 32'h46);
		rdchk(10'h307, 32'h78);
		rdchk(10'h308, 32'h22);
		$display("done fix loader");
	endtask : t_fix
	// ----------------------------------------
	// Run and verdict
	// ----------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_fixed();
		t_var();
		t_filter();
		t_fix();
		finish_test();
	end
	// Whole run is a few hundred cycles
	initial
	begin
		#400000;
		err_total++;
		finish_test();
	end
endmodule : tb
`default_nettype wire
